/* hdl/cqi_pkg.sv */
// cqi_pkg: constants, register map and carrier types for the counter input channel.
// Assumes a 125 MHz system clock and a plain address/strobe register port.
package cqi_pkg;
	// clock and time base
	localparam int CLK_MHZ       = 125;
	localparam int INT_SRC_MHZ   = 66;
	localparam int FILT_TICK_US  = 1;
	localparam int FILT_TICK_CYC = FILT_TICK_US * CLK_MHZ;
	localparam int FILT_W        = 16;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL                  = 8'h00;
	localparam logic [7:0] OFS_INIT                  = 8'h04;
	localparam logic [7:0] OFS_SOURCE_GLITCH_FILTER  = 8'h08;
	localparam logic [7:0] OFS_GATE_GLITCH_FILTER    = 8'h0C;
	localparam logic [7:0] OFS_PHASE_A_GLITCH_FILTER = 8'h10;
	localparam logic [7:0] OFS_PHASE_B_GLITCH_FILTER = 8'h14;
	localparam logic [7:0] OFS_INDEX_GLITCH_FILTER   = 8'h18;
	localparam logic [7:0] OFS_RESULT_LO             = 8'h1C;
	localparam logic [7:0] OFS_RESULT_HI             = 8'h20;
	localparam logic [7:0] OFS_STATUS                = 8'h24;

	// reset values
	localparam logic [31:0] RST_INIT = 32'h0000_0000;
	localparam logic [14:0] RST_CTRL = 15'h0000;

	// filter slots, also bit positions in the pin carrier
	localparam int FI_SRC  = 0;
	localparam int FI_GATE = 1;
	localparam int FI_A    = 2;
	localparam int FI_B    = 3;
	localparam int FI_Z    = 4;
	localparam int N_FILT  = 5;

	// status bit cleared by writing one
	localparam int ST_DONE_BIT = 7;

	// float packing
	localparam logic [10:0] F64_BIAS   = 11'h3FF;
	localparam logic [10:0] F32_REBIAS = 11'h380;

	typedef enum logic [1:0] {
		MODE_COUNT  = 2'b00,
		MODE_QUAD   = 2'b01,
		MODE_PERIOD = 2'b10,
		MODE_PWIDTH = 2'b11
	} cqi_mode_t;

	typedef enum logic [1:0] {
		DEC_1X = 2'b00,
		DEC_2X = 2'b01,
		DEC_4X = 2'b10
	} cqi_dec_t;

	typedef enum logic [2:0] {
		ZP_ZHIGH = 3'b000,
		ZP_ALBL  = 3'b001,
		ZP_ALBH  = 3'b010,
		ZP_AHBL  = 3'b011,
		ZP_AHBH  = 3'b100
	} cqi_zphase_t;

	typedef enum logic [2:0] {
		FMT_I16                      = 3'b000,
		FMT_I32                      = 3'b001,
		FMT_HALFWORD_SWAPPED_INT32   = 3'b010,
		FMT_F32                      = 3'b011,
		FMT_HALFWORD_SWAPPED_FLOAT32 = 3'b100,
		FMT_F64                      = 3'b101,
		FMT_WORD_SWAPPED_FLOAT64     = 3'b110
	} cqi_fmt_t;

	// control register layout, bit 0 is mode lsb
	typedef struct packed {
		logic        run;
		cqi_fmt_t    fmt;
		cqi_zphase_t zphase;
		logic        zero_en;
		cqi_dec_t    decode;
		logic        invert;
		logic        gate_ext;
		logic        src_ext;
		cqi_mode_t   mode;
	} cqi_ctrl_t;

	// channel pins, source in bit 0
	typedef struct packed {
		logic z;
		logic b;
		logic a;
		logic gate;
		logic src;
	} cqi_pins_t;

	typedef struct packed {
		logic done;
		logic z;
		logic b;
		logic a;
		logic gate;
		logic src;
		logic gate_open;
		logic run;
	} cqi_status_t;
endpackage

/* hdl/cqi_glitch_filter.sv */
// cqi_glitch_filter: minimum pulse width filter on one synchronised input.
// Assumes din_i is already in the clock domain and tick_i is a 1 us enable.
`timescale 1ns/1ps
module cqi_glitch_filter #(
	parameter int W = 16
) (
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	input  wire logic         tick_i,
	input  wire logic [W-1:0] width_i,
	input  wire logic         din_i,
	output logic              dout_o
);
	logic [W-1:0] cnt_q;
	logic         dout_q;

	assign dout_o = dout_q;

	// a level must persist for width ticks before it passes; zero width passes at once
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q  <= '0;
			dout_q <= 1'b0;
		end else if (din_i == dout_q) begin
			cnt_q <= '0;
		end else if (width_i == '0) begin
			dout_q <= din_i;
		end else if (tick_i) begin
			if (cnt_q >= W'(width_i - 1'b1)) begin
				dout_q <= din_i;
				cnt_q  <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_FILT_MIN: assert property ((din_i != dout_q) && (cnt_q == '0) && (width_i > W'(1))
		|=> dout_q == $past(dout_q))
		else $error("filter passed a pulse shorter than its width");
	AST_FILT_FOLLOW: assert property ($changed(dout_q) |-> dout_q == $past(din_i))
		else $error("filter output took a value the input never had");
endmodule

/* hdl/cqi_counter_quadrature_input.sv */
// cqi_counter_quadrature_input: one counter input channel with quadrature decoder.
// Assumes pins are asynchronous to clock_i and software uses the plain register port.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module cqi_counter_quadrature_input
	import cqi_pkg::*;
#(
	parameter int FILT_W_P = FILT_W
) (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire cqi_pins_t   pins_i,
	output logic      [63:0] result_o,
	output logic             meas_done_o
);
	if (FILT_W_P < 2 || FILT_W_P > 32) begin : g_bad_width
		$error("FILT_W_P must lie between 2 and 32");
	end

	localparam int DIV_W = $clog2(FILT_TICK_CYC);

	// exact double of a signed 32-bit integer
	function automatic logic [63:0] to_f64(input logic [31:0] v);
		logic        sgn;
		logic [31:0] mag;
		logic [31:0] norm;
		logic [4:0]  msb;
		sgn = v[31];
		mag = sgn ? (~v + 32'h1) : v;
		msb = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				msb = 5'(i);
			end
		end
		norm = mag << (5'h1F - msb);
		if (mag == 32'h0) begin
			return 64'h0;
		end
		return {sgn, F64_BIAS + {6'h00, msb}, norm[30:0], 21'h000000};
	endfunction

	// single from double; mantissa truncated, so large values round toward zero
	function automatic logic [31:0] to_f32(input logic [63:0] d);
		logic [7:0] e;
		e = (d[62:52] == 11'h0) ? 8'h00 : 8'(d[62:52] - F32_REBIAS);
		return {d[63], e, d[51:29]};
	endfunction

	function automatic logic [63:0] fmt_result(input cqi_fmt_t f, input logic [31:0] v);
		logic [63:0] d;
		logic [31:0] s;
		d = to_f64(v);
		s = to_f32(d);
		case (f)
			FMT_I16:                      return {48'h0, v[15:0]};
			FMT_HALFWORD_SWAPPED_INT32:   return {32'h0, v[15:0], v[31:16]};
			FMT_F32:                      return {32'h0, s};
			FMT_HALFWORD_SWAPPED_FLOAT32: return {32'h0, s[15:0], s[31:16]};
			FMT_F64:                      return d;
			FMT_WORD_SWAPPED_FLOAT64:     return {d[31:0], d[63:32]};
			default:                      return {32'h0, v};
		endcase
	endfunction

	cqi_pins_t          sync1_q;
	cqi_pins_t          sync2_q;
	logic [N_FILT-1:0]  sync_v;
	logic [N_FILT-1:0]  filt_v;
	logic [N_FILT-1:0]  cur_v;
	logic [N_FILT-1:0]  prev_q;
	logic [N_FILT-1:0]  rise_v;
	logic [N_FILT-1:0]  fall_v;
	logic [DIV_W-1:0]   div_q;
	logic               us_tick;
	logic [7:0]         acc_q;
	logic [8:0]         acc_sum;
	logic               int_tick;
	cqi_ctrl_t          ctrl_q;
	logic [31:0]        init_q;
	logic [FILT_W_P-1:0] fw_q [N_FILT];
	logic               run_prev_q;
	logic               start;
	logic               src_lvl;
	logic               gate_lvl;
	logic               a_lvl;
	logic               b_lvl;
	logic               gate_open;
	logic               src_step;
	logic               a_edge;
	logic               b_edge;
	logic               q_up;
	logic               q_dn;
	logic               phase_ok;
	logic               zero_hit;
	logic [31:0]        cnt_q;
	logic [31:0]        cnt_d;
	logic [15:0]        cnt_hi;
	logic               m_lvl;
	logic               m_rise;
	logic               m_fall;
	logic [31:0]        tcnt_q;
	logic [31:0]        tcnt_d;
	logic [31:0]        meas_q;
	logic [31:0]        meas_d;
	logic               armed_q;
	logic               armed_d;
	logic               m_done;
	logic               done_q;
	logic               done_st_q;
	logic [63:0]        result_q;
	logic [31:0]        rd_val;
	logic [31:0]        rdata_q;
	logic [7:0]         filt_off;
	logic               filt_hit;
	logic [2:0]         filt_idx;
	logic               wr_ctrl;
	logic               wr_init;
	logic               wr_filt;
	logic               wr_status;
	cqi_status_t        status;

	// two-flop synchroniser on every pin before anything reads it
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins_i;
			sync2_q <= sync1_q;
		end
	end
	assign sync_v = sync2_q;

	// 1 us enable for the width filters
	assign us_tick = (div_q == DIV_W'(FILT_TICK_CYC - 1));
	// 66 MHz enable: phase accumulator, jitter of one 8 ns cycle traded for no second clock
	assign acc_sum  = {1'b0, acc_q} + 9'(INT_SRC_MHZ);
	assign int_tick = (acc_sum >= 9'(CLK_MHZ));
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			div_q <= '0;
			acc_q <= 8'h00;
		end else begin
			div_q <= us_tick ? '0 : div_q + 1'b1;
			acc_q <= int_tick ? 8'(acc_sum - 9'(CLK_MHZ)) : acc_sum[7:0];
		end
	end

	// register write decode
	assign filt_off  = addr_i - OFS_SOURCE_GLITCH_FILTER;
	assign filt_hit  = (addr_i >= OFS_SOURCE_GLITCH_FILTER) &&
	                   (addr_i <= OFS_INDEX_GLITCH_FILTER) && (addr_i[1:0] == 2'b00);
	assign filt_idx  = filt_off[4:2];
	assign wr_ctrl   = wr_i && (addr_i == OFS_CTRL);
	assign wr_init   = wr_i && (addr_i == OFS_INIT);
	assign wr_filt   = wr_i && filt_hit;
	assign wr_status = wr_i && (addr_i == OFS_STATUS);

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_q <= cqi_ctrl_t'(RST_CTRL);
			init_q <= RST_INIT;
			for (int i = 0; i < N_FILT; i++) begin
				fw_q[i] <= '0;
			end
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= cqi_ctrl_t'(wdata_i[14:0]);
			end
			if (wr_init) begin
				init_q <= wdata_i;
			end
			if (wr_filt) begin
				fw_q[filt_idx] <= wdata_i[FILT_W_P-1:0];
			end
		end
	end

	// one filter per input, each with its own width register
	for (genvar gi = 0; gi < N_FILT; gi++) begin : g_filt
		cqi_glitch_filter #(
			.W(FILT_W_P)
		) u_filt (
			.clock_i (clock_i),
			.reset_i (reset_i),
			.tick_i  (us_tick),
			.width_i (fw_q[gi]),
			.din_i   (sync_v[gi]),
			.dout_o  (filt_v[gi])
		);
	end

	// levels after filtering; inversion acts on the source input only
	assign src_lvl  = filt_v[FI_SRC] ^ ctrl_q.invert;
	assign gate_lvl = filt_v[FI_GATE];
	assign a_lvl    = filt_v[FI_A];
	assign b_lvl    = filt_v[FI_B];
	assign cur_v    = {filt_v[FI_Z], b_lvl, a_lvl, gate_lvl, src_lvl};
	assign rise_v   = cur_v & ~prev_q;
	assign fall_v   = ~cur_v & prev_q;

	// start and gating
	assign start     = ctrl_q.run && !run_prev_q;
	assign gate_open = ctrl_q.run && (ctrl_q.gate_ext ? gate_lvl : 1'b1);
	assign src_step  = ctrl_q.src_ext ? rise_v[FI_SRC] : int_tick;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			prev_q     <= '0;
			run_prev_q <= 1'b0;
		end else begin
			prev_q     <= cur_v;
			run_prev_q <= ctrl_q.run;
		end
	end

	// quadrature steps; forward order is 00, 10, 11, 01
	assign a_edge = rise_v[FI_A] | fall_v[FI_A];
	assign b_edge = rise_v[FI_B] | fall_v[FI_B];
	always_comb begin
		q_up = 1'b0;
		q_dn = 1'b0;
		// both phases moving at once is illegal and ignored
		if (!(a_edge && b_edge)) begin
			case (ctrl_q.decode)
				DEC_1X: begin
					q_up = rise_v[FI_A] && !b_lvl;
					q_dn = fall_v[FI_A] && !b_lvl;
				end
				DEC_2X: begin
					q_up = a_edge && (a_lvl != b_lvl);
					q_dn = a_edge && (a_lvl == b_lvl);
				end
				default: begin
					q_up = (a_edge && (a_lvl != b_lvl)) || (b_edge && (a_lvl == b_lvl));
					q_dn = (a_edge && (a_lvl == b_lvl)) || (b_edge && (a_lvl != b_lvl));
				end
			endcase
		end
	end

	// index condition: rising Z, optionally qualified by the A/B levels
	always_comb begin
		case (ctrl_q.zphase)
			ZP_ZHIGH: phase_ok = 1'b1;
			ZP_ALBL:  phase_ok = !a_lvl && !b_lvl;
			ZP_ALBH:  phase_ok = !a_lvl && b_lvl;
			ZP_AHBL:  phase_ok = a_lvl && !b_lvl;
			ZP_AHBH:  phase_ok = a_lvl && b_lvl;
			default:  phase_ok = 1'b0;
		endcase
	end
	assign zero_hit = ctrl_q.run && ctrl_q.zero_en && rise_v[FI_Z] && phase_ok;

	// position / event counter; start and index reload win over a step
	always_comb begin
		cnt_d = cnt_q;
		if (start) begin
			cnt_d = init_q;
		end else begin
			unique case (ctrl_q.mode)
				MODE_COUNT: begin
					if (gate_open && src_step) begin
						cnt_d = cnt_q + 32'h1;
					end
				end
				MODE_QUAD: begin
					if (zero_hit) begin
						cnt_d = init_q;
					end else if (gate_open && q_up) begin
						cnt_d = cnt_q + 32'h1;
					end else if (gate_open && q_dn) begin
						cnt_d = cnt_q - 32'h1;
					end
				end
				MODE_PERIOD, MODE_PWIDTH: cnt_d = cnt_q;
			endcase
		end
	end
	assign cnt_hi = cnt_q[31:16];

	// measured signal is the source pin with internal timebase, the gate pin otherwise
	assign m_lvl  = ctrl_q.src_ext ? gate_lvl : src_lvl;
	assign m_rise = ctrl_q.src_ext ? rise_v[FI_GATE] : rise_v[FI_SRC];
	assign m_fall = ctrl_q.src_ext ? fall_v[FI_GATE] : fall_v[FI_SRC];

	// the first edge after start only arms, so no partial interval is reported
	always_comb begin
		tcnt_d  = tcnt_q;
		meas_d  = meas_q;
		armed_d = armed_q;
		m_done  = 1'b0;
		if (!ctrl_q.run || start) begin
			tcnt_d  = 32'h0;
			armed_d = 1'b0;
		end else if (ctrl_q.mode == MODE_PERIOD) begin
			if (m_rise) begin
				meas_d  = armed_q ? tcnt_q : meas_q;
				m_done  = armed_q;
				armed_d = 1'b1;
				tcnt_d  = src_step ? 32'h1 : 32'h0;
			end else if (src_step) begin
				tcnt_d = tcnt_q + 32'h1;
			end
		end else if (ctrl_q.mode == MODE_PWIDTH) begin
			if (m_fall && armed_q) begin
				meas_d  = tcnt_q;
				m_done  = 1'b1;
				armed_d = 1'b0;
				tcnt_d  = 32'h0;
			end else if (m_rise) begin
				armed_d = 1'b1;
				tcnt_d  = src_step ? 32'h1 : 32'h0;
			end else if (src_step && m_lvl) begin
				tcnt_d = tcnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q   <= 32'h0;
			tcnt_q  <= 32'h0;
			meas_q  <= 32'h0;
			armed_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			tcnt_q  <= tcnt_d;
			meas_q  <= meas_d;
			armed_q <= armed_d;
			done_q  <= m_done;
		end
	end

	// result formatting, one cycle behind the counter
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			result_q <= 64'h0;
		end else begin
			result_q <= fmt_result(ctrl_q.fmt, ctrl_q.mode[1] ? meas_q : cnt_q);
		end
	end

	// sticky done flag: a new measurement wins over a clear in the same cycle
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			done_st_q <= 1'b0;
		end else if (m_done) begin
			done_st_q <= 1'b1;
		end else if (wr_status && wdata_i[ST_DONE_BIT]) begin
			done_st_q <= 1'b0;
		end
	end

	assign status = '{done: done_st_q, z: filt_v[FI_Z], b: b_lvl, a: a_lvl, gate: gate_lvl,
	                  src: src_lvl, gate_open: gate_open, run: ctrl_q.run};

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0;
		if (filt_hit) begin
			rd_val = 32'(fw_q[filt_idx]);
		end else begin
			case (addr_i)
				OFS_CTRL:      rd_val = 32'(ctrl_q);
				OFS_INIT:      rd_val = init_q;
				OFS_RESULT_LO: rd_val = result_q[31:0];
				OFS_RESULT_HI: rd_val = result_q[63:32];
				OFS_STATUS:    rd_val = 32'(status);
				default:       rd_val = 32'h0;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rd_i ? rd_val : 32'h0;
		end
	end

	assign rdata_o     = rdata_q;
	assign result_o    = result_q;
	assign meas_done_o = done_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_COUNT_STEP: assert property (ctrl_q.mode == MODE_COUNT && gate_open && src_step && !start
		|=> cnt_q == $past(cnt_q) + 32'h1)
		else $error("count mode missed a source step");
	AST_SRC_SEL: assert property (ctrl_q.mode == MODE_COUNT && !start &&
		!(ctrl_q.src_ext ? rise_v[FI_SRC] : int_tick) |=> $stable(cnt_q))
		else $error("counter moved without a selected source tick");
	AST_GATE_EXT: assert property (ctrl_q.mode == MODE_COUNT && ctrl_q.gate_ext && !gate_lvl
		&& !start |=> $stable(cnt_q))
		else $error("counter moved with the external gate closed");
	AST_INVERT: assert property ($rose(filt_v[FI_SRC]) && $stable(ctrl_q.invert) && !ctrl_q.invert
		|-> rise_v[FI_SRC] && !fall_v[FI_SRC])
		else $error("plain source edge not seen as rising");
	AST_GATE_FILT: assert property ($changed(filt_v[FI_GATE]) && fw_q[FI_GATE] != '0
		|-> $past(us_tick))
		else $error("gate filter changed off the microsecond tick");
	AST_A_FILT: assert property ($changed(filt_v[FI_A]) |-> filt_v[FI_A] == $past(sync_v[FI_A]))
		else $error("phase A filter output not from its input");
	AST_LOAD_INIT: assert property (start |=> cnt_q == $past(init_q))
		else $error("start did not load the initial count");
	AST_QUAD_4X: assert property (ctrl_q.mode == MODE_QUAD && ctrl_q.decode == DEC_4X && gate_open
		&& !start && !zero_hit && rise_v[FI_B] && !a_edge && a_lvl
		|=> cnt_q == $past(cnt_q) + 32'h1)
		else $error("4x decoding missed a forward B edge");
	AST_ZERO_RELOAD: assert property (ctrl_q.mode == MODE_QUAD && zero_hit && !start
		|=> cnt_q == $past(init_q))
		else $error("index did not reload the initial count");
	AST_ZPHASE: assert property (zero_hit && ctrl_q.zphase == ZP_AHBL
		|-> a_lvl && !b_lvl && rise_v[FI_Z])
		else $error("index reload outside the selected phase");
	// count and quad both report the counter, so either mode must show the swapped halves
	AST_SWAP32: assert property ($past(ctrl_q.fmt) == FMT_HALFWORD_SWAPPED_INT32 &&
		!$past(ctrl_q.mode[1]) |-> result_q[15:0] == $past(cnt_hi))
		else $error("swapped integer halves wrong");
	AST_PERIOD: assert property (ctrl_q.mode == MODE_PERIOD && ctrl_q.run && !start && armed_q
		&& m_rise |=> meas_q == $past(tcnt_q) && meas_done_o)
		else $error("period result not the tick count");

	COV_COUNT: cover property (ctrl_q.mode == MODE_COUNT && gate_open && src_step);
	COV_ZERO: cover property (ctrl_q.mode == MODE_QUAD && zero_hit);
	COV_PERIOD: cover property (ctrl_q.mode == MODE_PERIOD && m_done);
	COV_PWIDTH: cover property (ctrl_q.mode == MODE_PWIDTH && m_done);
endmodule

/* bench/cqi_encoder_model.sv */
// cqi_encoder_model: behavioural encoder, pulse source and gate for one channel.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
module cqi_encoder_model
	import cqi_pkg::*;
(
	input  wire logic clock_i,
	output cqi_pins_t pins_o
);
	logic [1:0] ph_q = 2'h0;
	cqi_pins_t  p_q  = '0;

	// push-pull drivers, so no line is ever left floating
	assign pins_o = p_q;

	task automatic hold(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// forward order 00,10,11,01; a and b never move together
	task automatic step(input bit fwd);
		ph_q = fwd ? ph_q + 2'h1 : ph_q - 2'h1;
		@(posedge clock_i);
		p_q.a <= ph_q[0] ^ ph_q[1];
		p_q.b <= ph_q[1];
		hold(20);
	endtask

	// one pulse on pin slot i, widths in clock cycles
	task automatic pulse(input int i, input int hi, input int lo);
		@(posedge clock_i);
		p_q[i] <= 1'b1;
		hold(hi);
		p_q[i] <= 1'b0;
		hold(lo);
	endtask

	task automatic level(input int i, input logic v);
		@(posedge clock_i);
		p_q[i] <= v;
	endtask
endmodule

/* bench/test_counter_quadrature_input.sv */
// test_counter_quadrature_input: self-checking bench for the counter channel.
// Assumes the encoder model drives all pins and filter widths start at zero.
`timescale 1ns/1ps
module test_counter_quadrature_input
	import cqi_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  addr_i  = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [31:0] rdata_o;
	cqi_pins_t   pins;
	logic [63:0] result_o;
	logic        meas_done_o;
	logic [31:0] rv;
	cqi_ctrl_t   cfg = '0;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          dones = 0;
	// expected formats of 32'h12345678, with the bits that matter
	logic [63:0] fx [7] = '{64'h5678, 64'h12345678, 64'h56781234, 64'h4D91A2B3,
		64'hA2B34D91, 64'h41B2345678000000, 64'h7800000041B23456};
	logic [63:0] fm [7] = '{64'hFFFF, 64'hFFFFFFFF, 64'hFFFFFFFF, 64'hFFFFFFFF,
		64'hFFFFFFFF, '1, '1};

	cqi_counter_quadrature_input cqi_counter_quadrature_input_inst (
		.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins),
		.result_o(result_o), .meas_done_o(meas_done_o));
	cqi_encoder_model cqi_encoder_model_inst (.clock_i(clock_i), .pins_o(pins));

	always #4 clock_i = ~clock_i;

	// cycle ceiling well above the whole sequence, and a count of results
	always @(posedge clock_i) begin
		cycles++;
		if (meas_done_o === 1'b1) dones++;
		if (cycles == 40000) begin
			num_errors++;
			$display("[FAIL] %0t run did not finish", $time);
			close_out();
		end
	end

	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		rv = rdata_o;
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	// run 0 then 1, so every start reloads the initial count
	task automatic start;
		cfg.run = 1'b0;
		wr(OFS_CTRL, {17'h0, cfg});
		cfg.run = 1'b1;
		wr(OFS_CTRL, {17'h0, cfg});
		w(10);
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rng(input logic [63:0] got, input int lo, input int hi, input string m);
		tests_run++;
		if (((got >= 64'(lo)) && (got <= 64'(hi))) !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s got %0d", $time, m, got);
		end
	endtask

	initial begin
		int i;
		int s;
		int k;
		logic [63:0] e;
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		// reset values and an unmapped place
		rd(OFS_CTRL);
		chk(64'(rv), 64'h0, "ctrl reset");
		rd(OFS_INIT);
		chk(64'(rv), 64'h0, "init reset");
		rd(8'h28);
		chk(64'(rv), 64'h0, "unmapped read");
		// external source events, internal gate
		cfg.src_ext = 1'b1;
		start();
		repeat (3) cqi_encoder_model_inst.pulse(FI_SRC, 10, 10);
		w(10);
		chk(result_o, 64'h3, "event count");
		rd(OFS_RESULT_LO);
		chk(64'(rv), 64'h3, "result read");
		w(1);
		chk(64'(rdata_o), 64'h0, "read data one cycle");
		// inversion moves the counted edge to the pin's fall
		cfg.invert = 1'b1;
		start();
		rd(OFS_STATUS);
		chk(64'(rv[2]), 64'h1, "inverted level");
		cqi_encoder_model_inst.pulse(FI_SRC, 10, 10);
		w(10);
		chk(result_o, 64'h1, "inverted count");
		// external gate closed, then open
		cfg.invert = 1'b0;
		cfg.gate_ext = 1'b1;
		start();
		repeat (2) cqi_encoder_model_inst.pulse(FI_SRC, 10, 10);
		w(10);
		chk(result_o, 64'h0, "gate closed");
		cqi_encoder_model_inst.level(FI_GATE, 1'b1);
		w(10);
		repeat (2) cqi_encoder_model_inst.pulse(FI_SRC, 10, 10);
		w(10);
		chk(result_o, 64'h2, "gate open");
		// gate filter of 2 us holds the open level through a short low
		wr(OFS_GATE_GLITCH_FILTER, 32'h2);
		cqi_encoder_model_inst.level(FI_GATE, 1'b0);
		w(60);
		rd(OFS_STATUS);
		chk(64'(rv[3]), 64'h1, "short gate low");
		w(300);
		rd(OFS_STATUS);
		chk(64'(rv[3]), 64'h0, "long gate low");
		wr(OFS_GATE_GLITCH_FILTER, 32'h0);
		cfg.gate_ext = 1'b0;
		// source filter of 2 us drops 60 cycles, passes 400
		wr(OFS_SOURCE_GLITCH_FILTER, 32'h2);
		start();
		cqi_encoder_model_inst.pulse(FI_SRC, 60, 400);
		w(2);
		chk(result_o, 64'h0, "short source");
		cqi_encoder_model_inst.pulse(FI_SRC, 400, 400);
		w(2);
		chk(result_o, 64'h1, "long source");
		wr(OFS_SOURCE_GLITCH_FILTER, 32'h0);
		// internal 66 MHz: 250 cycles hold 132 ticks
		cfg.src_ext = 1'b0;
		start();
		e = result_o;
		w(250);
		rng(result_o - e, 131, 133, "internal rate");
		// period and pulse width in internal ticks
		cfg.mode = MODE_PERIOD;
		start();
		s = dones;
		repeat (2) cqi_encoder_model_inst.pulse(FI_SRC, 125, 125);
		w(10);
		chk(64'(dones - s), 64'h1, "one period");
		rng(result_o, 131, 133, "period");
		rd(OFS_STATUS);
		chk(64'(rv[7]), 64'h1, "done flag");
		wr(OFS_STATUS, 32'h80);
		rd(OFS_STATUS);
		chk(64'(rv[7]), 64'h0, "done cleared");
		cfg.mode = MODE_PWIDTH;
		start();
		repeat (2) cqi_encoder_model_inst.pulse(FI_SRC, 250, 50);
		w(10);
		rng(result_o, 131, 133, "pulse width");
		// quadrature: one full cycle each way per decoding
		wr(OFS_INIT, 32'd100);
		cfg.mode = MODE_QUAD;
		for (k = 0; k < 3; k++) begin
			cfg.decode = cqi_dec_t'(k);
			start();
			chk(result_o, 64'd100, "initial load");
			repeat (4) cqi_encoder_model_inst.step(1'b1);
			w(2);
			chk(result_o, 64'd100 + (64'd1 << k), "forward");
			repeat (4) cqi_encoder_model_inst.step(1'b0);
			w(2);
			chk(result_o, 64'd100, "reverse");
		end
		// every index condition against every a/b state
		cfg.zero_en = 1'b1;
		for (i = 0; i < 5; i++) begin
			for (s = 0; s < 4; s++) begin
				cfg.zphase = cqi_zphase_t'(i);
				start();
				repeat (s) cqi_encoder_model_inst.step(1'b1);
				cqi_encoder_model_inst.pulse(FI_Z, 10, 10);
				w(2);
				k = ((s == 1 || s == 2) ? 2 : 0) + ((s >= 2) ? 1 : 0);
				e = (i == 0 || i - 1 == k) ? 64'd100 : 64'd100 + 64'(s);
				chk(result_o, e, "index reload");
				repeat (s) cqi_encoder_model_inst.step(1'b0);
			end
		end
		// index disabled, then index filter of 2 us
		cfg.zero_en = 1'b0;
		cfg.zphase = ZP_ZHIGH;
		start();
		cqi_encoder_model_inst.step(1'b1);
		cqi_encoder_model_inst.pulse(FI_Z, 10, 10);
		w(2);
		chk(result_o, 64'd101, "index disabled");
		cfg.zero_en = 1'b1;
		wr(OFS_INDEX_GLITCH_FILTER, 32'h2);
		start();
		cqi_encoder_model_inst.step(1'b1);
		cqi_encoder_model_inst.pulse(FI_Z, 60, 400);
		w(2);
		chk(result_o, 64'd101, "short index");
		cqi_encoder_model_inst.pulse(FI_Z, 400, 400);
		w(2);
		chk(result_o, 64'd100, "long index");
		// phase a filter of 2 us delays a forward a edge past the step
		wr(OFS_PHASE_A_GLITCH_FILTER, 32'h2);
		cqi_encoder_model_inst.step(1'b1);
		w(2);
		chk(result_o, 64'd100, "short phase a");
		w(300);
		chk(result_o, 64'd101, "long phase a");
		wr(OFS_PHASE_A_GLITCH_FILTER, 32'h0);
		// every result format of one fixed count
		cfg.zero_en = 1'b0;
		wr(OFS_INIT, 32'h1234_5678);
		for (i = 0; i < 7; i++) begin
			cfg.fmt = cqi_fmt_t'(i);
			start();
			chk(result_o & fm[i], fx[i], "format");
		end
		rd(OFS_RESULT_HI);
		chk(64'(rv), 64'h78000000, "swapped high word");
		w(5);
		close_out();
	end
endmodule
